// File: src/one_wire_debug_pkg.sv
// one_wire_debug_pkg: shared constants and types for the one-wire debug port
// assumes: included before the transmitter and the port top; 32-bit ahb-lite data

package one_wire_debug_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets, low address bits only)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00; // debugger_control_reg
  localparam logic [7:0] STAT_OFS = 8'h04; // status, error flags w1c
  localparam logic [7:0] TXD_OFS  = 8'h08; // byte to send on the line
  localparam logic [7:0] RXD_OFS  = 8'h0c; // last byte received
  localparam logic [7:0] BAUD_OFS = 8'h10; // measured bit period, clocks
  localparam logic [7:0] RUN_OFS  = 8'h14; // runtime counter

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00; // control after reset
  localparam int MODE_BIT  = 7;            // debug_mode_bit
  localparam int BPEN_BIT  = 5;            // breakpoint enable
  localparam int ST_MODE   = 0;            // status: debug mode
  localparam int ST_CAL    = 1;            // status: baud calibrated
  localparam int ST_TX     = 2;            // status: send busy/pending
  localparam int ST_RX     = 3;            // status: receive byte ready
  localparam int ST_ERR    = 4;            // status: err flags [6:4]
  localparam int ST_LINK   = 8;            // status: link state [10:8]

  // ----------------------------------------------------------------
  // character framing and timing counts (in bit times; MIN_BIT_CLKS and RUN_MAX in clocks)
  // ----------------------------------------------------------------
  localparam int DATA_BITS      = 8;  // data bits per character
  localparam int STOP_IDX       = 9;  // frame slot of the stop bit
  localparam int CAL_LOW_BITS   = 8;  // low run of the calibration byte
  localparam int BREAK_BITS     = 9;  // low run that counts as a break
  localparam int ERR_BREAK_BITS = 42; // four characters of 10.5 bits
  localparam int MIN_BIT_CLKS   = 4;  // fastest usable bit period
  localparam logic [15:0] RUN_MAX = 16'hffff; // runtime saturation

  // link states, gray along idle -> receive -> error -> hold
  typedef enum logic [2:0] {
    LK_UNCAL = 3'b000,
    LK_CAL   = 3'b001,
    LK_IDLE  = 3'b011,
    LK_RX    = 3'b010,
    LK_ERR   = 3'b110,
    LK_HOLD  = 3'b111
  } link_state_e;

endpackage

// File: src/one_wire_debug_tx.sv
// one_wire_debug_tx: character transmitter for the open-drain debug line
// assumes: line input synchronous to core_clk; caller only starts on an idle line

`timescale 1ns/1ps

module one_wire_debug_tx import one_wire_debug_pkg::*; #(
  parameter int BP_W = 10
)(
  input  wire logic            core_clk,
  input  wire logic            rstn,
  input  wire logic            abort,       // drop the character at once
  input  wire logic            start,       // send txByte
  input  wire logic [7:0]      txByte,
  input  wire logic [BP_W-1:0] bitPeriod,   // clocks per bit
  input  wire logic            debugLineIn,
  output logic                 busy,
  output logic                 drive,       // pull the line low
  output logic                 collision    // one-cycle pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [9:0]    frame, next_frame; // stop, data lsb first, start
  logic [3:0]    idx, next_idx;     // frame slot being sent
  logic [BP_W:0] cnt, next_cnt;     // clocks into the slot
  logic          next_busy;
  logic          next_coll;
  logic [BP_W:0] dur;               // length of this slot
  logic [BP_W:0] half;              // mid-slot sample point

  // low slots pull the line, high slots just release it
  assign drive = busy & ~frame[0];

  // next-value logic for one character
  always_comb begin
    next_frame = frame;
    next_idx   = idx;
    next_cnt   = cnt;
    next_busy  = busy;
    next_coll  = 1'b0;
    half       = {2'b00, bitPeriod[BP_W-1:1]};
    // stop slot is one and a half bit times
    dur = (idx == 4'(STOP_IDX)) ? ({1'b0, bitPeriod} + half) : {1'b0, bitPeriod};
    if (abort) begin
      next_busy = 1'b0;
    end else if (!busy) begin
      if (start) begin
        next_frame = {1'b1, txByte, 1'b0};
        next_idx   = 4'h0;
        next_cnt   = '0;
        next_busy  = 1'b1;
      end
    end else if (frame[0] && !debugLineIn && cnt == half) begin
      // released but low at mid-bit: someone else is sending
      next_coll = 1'b1;
      next_busy = 1'b0;
    end else if (cnt == dur - 1'b1) begin
      next_cnt = '0;
      if (idx == 4'(STOP_IDX)) begin
        next_busy = 1'b0;
      end else begin
        next_frame = {1'b1, frame[9:1]};
        next_idx   = idx + 4'h1;
      end
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      frame     <= 10'h3ff;
      idx       <= 4'h0;
      cnt       <= '0;
      busy      <= 1'b0;
      collision <= 1'b0;
    end else begin
      frame     <= next_frame;
      idx       <= next_idx;
      cnt       <= next_cnt;
      busy      <= next_busy;
      collision <= next_coll;
    end
  end

endmodule

// File: src/one_wire_debug_port.sv
// one_wire_debug_port: debug-line front end, debug mode and runtime counter
// assumes: one ahb-lite master, inputs synchronous to core_clk, external pull-up

`timescale 1ns/1ps

module one_wire_debug_port import one_wire_debug_pkg::*; #(
  parameter int MAX_BIT_CLKS = 512 // slowest bit period
)(
  input  wire logic        core_clk,
  input  wire logic        rstn,             // por, brown-out, watchdog, pin
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        debugLineIn,
  output logic             debugLineOut,
  output logic             debugLineOe,
  input  wire logic        breakpointHit,    // cpu decoded breakpoint_opcode
  input  wire logic        flashReadProtect,
  input  wire logic        watchdogEnabled,
  input  wire logic        deepStop,
  output logic             cpuIdle,
  output logic             watchdogRefresh,
  output logic             sysResetReq
);

  // ----------------------------------------------------------------
  // derived constants
  // ----------------------------------------------------------------
  localparam int BP_W = $clog2(MAX_BIT_CLKS) + 1;
  localparam logic [15:0] UNCAL_BRK = 16'(CAL_LOW_BITS * MAX_BIT_CLKS + 1);
  localparam logic [15:0] ERR_MAX   = 16'(ERR_BREAK_BITS * MAX_BIT_CLKS);

  // ----------------------------------------------------------------
  // link state
  // ----------------------------------------------------------------
  link_state_e     state, next_state;
  logic [15:0]     cnt, next_cnt;          // shared phase counter
  logic [3:0]      rxIdx, next_rxIdx;      // frame slot being sampled
  logic [7:0]      rxShift, next_rxShift;
  logic [BP_W-1:0] bitPeriod, next_bitPeriod; // zero while uncalibrated
  logic [15:0]     lowRun, next_lowRun;    // foreign low run length
  logic            prevLine;
  logic            next_lineOe;
  logic            frameErr, breakHit, rxDone;
  logic            calibrated;
  logic [15:0]     bp16, brkThr, errClks;
  logic            txBusy, txDrive, txColl, txStart, txAbort;

  // ----------------------------------------------------------------
  // software-visible state
  // ----------------------------------------------------------------
  logic [7:0]  ctrl, next_ctrl;            // debugger_control_reg
  logic        txPending, next_txPending;
  logic [7:0]  txByte, next_txByte;
  logic [7:0]  rxData, next_rxData;
  logic        rxFull, next_rxFull;
  logic [2:0]  errFlags, next_errFlags;    // collision, framing, break
  logic [15:0] runtime, next_runtime;
  logic        wrPend, next_wrPend;        // write data phase due
  logic [7:0]  wrAddr, next_wrAddr;
  logic [31:0] next_hrdata;
  logic        next_wdRefresh, next_sysResetReq;
  logic        postRst;                    // first cycle after reset
  logic        strapLow;                   // line level in last reset cycle
  logic        addrAcc, rdRxd;
  logic        wCtrl, wStat, wTxd;

  assign calibrated = (bitPeriod != '0);
  assign bp16       = 16'(bitPeriod);
  assign txStart    = (state == LK_IDLE) && txPending && debugLineIn;
  assign txAbort    = (state != LK_IDLE);

  // transmitter, only ever started from an idle receiver
  one_wire_debug_tx #(
    .BP_W (BP_W)
  ) u_tx (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .abort       (txAbort),
    .start       (txStart),
    .txByte      (txByte),
    .bitPeriod   (bitPeriod),
    .debugLineIn (debugLineIn),
    .busy        (txBusy),
    .drive       (txDrive),
    .collision   (txColl)
  );

  // ----------------------------------------------------------------
  // link: auto-baud, receiver, break and error handling
  // ----------------------------------------------------------------
  // next-value logic for the link
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_rxIdx     = rxIdx;
    next_rxShift   = rxShift;
    next_bitPeriod = bitPeriod;
    frameErr       = 1'b0;
    rxDone         = 1'b0;
    // before calibration only a run longer than any valid 80h counts
    brkThr  = calibrated ? 16'(BREAK_BITS * bp16) : UNCAL_BRK;
    errClks = calibrated ? 16'(ERR_BREAK_BITS * bp16) : ERR_MAX;
    // own drive is not mistaken for a break
    if (debugLineIn || debugLineOe || txDrive) begin
      next_lowRun = 16'h0;
    end else begin
      next_lowRun = (lowRun == 16'hffff) ? lowRun : lowRun + 16'h1;
    end
    breakHit = (lowRun >= brkThr) && (state != LK_ERR) && (state != LK_HOLD);
    case (state)
      LK_UNCAL: begin
        // idle until the first falling edge
        if (prevLine && !debugLineIn) begin
          next_state = LK_CAL;
          next_cnt   = 16'h1;
        end
      end
      LK_CAL: begin
        if (!debugLineIn) begin
          next_cnt = cnt + 16'h1;
        end else if (cnt[15:3] >= 13'(MIN_BIT_CLKS) && cnt[15:3] <= 13'(MAX_BIT_CLKS)) begin
          // eight low bit times of the 80h byte
          next_bitPeriod = cnt[3 +: BP_W];
          next_state     = LK_IDLE;
        end else begin
          next_state = LK_UNCAL; // glitch or too fast a host
        end
      end
      LK_IDLE: begin
        // no receive while sending
        if (!txBusy && prevLine && !debugLineIn) begin
          next_state = LK_RX;
          next_cnt   = 16'(bitPeriod[BP_W-1:1]);
          next_rxIdx = 4'h0;
        end
      end
      LK_RX: begin
        if (cnt != 16'h0) begin
          next_cnt = cnt - 16'h1;
        end else begin
          next_cnt   = bp16 - 16'h1;
          next_rxIdx = rxIdx + 4'h1;
          if (rxIdx == 4'h0) begin
            if (debugLineIn) begin
              next_state = LK_IDLE; // start bit was a glitch
            end
          end else if (rxIdx == 4'(STOP_IDX)) begin
            if (!debugLineIn) begin
              frameErr = 1'b1;
            end else begin
              rxDone     = 1'b1;
              next_state = LK_IDLE;
            end
          end else begin
            next_rxShift = {debugLineIn, rxShift[7:1]};
          end
        end
      end
      LK_ERR: begin
        // drive the answering break
        if (cnt != 16'h0) begin
          next_cnt = cnt - 16'h1;
        end else begin
          next_state = LK_HOLD;
        end
      end
      LK_HOLD: begin
        // unit stays in reset until the line is high again
        if (debugLineIn) begin
          next_state     = LK_UNCAL;
          next_bitPeriod = '0;
        end
      end
      default: begin
        next_state = LK_UNCAL;
      end
    endcase
    // any serial error aborts whatever was in progress
    if (breakHit || frameErr || txColl) begin
      next_state     = LK_ERR;
      next_cnt       = errClks - 16'h1;
      next_bitPeriod = '0; // detector held in reset through the break
    end
    next_lineOe = (state == LK_ERR) || txDrive;
  end

  // link registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state        <= LK_UNCAL;
      cnt          <= 16'h0;
      rxIdx        <= 4'h0;
      rxShift      <= 8'h00;
      bitPeriod    <= '0;
      lowRun       <= 16'h0;
      prevLine     <= 1'b1;
      debugLineOe  <= 1'b0;
      debugLineOut <= 1'b0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      rxIdx        <= next_rxIdx;
      rxShift      <= next_rxShift;
      bitPeriod    <= next_bitPeriod;
      lowRun       <= next_lowRun;
      prevLine     <= debugLineIn;
      debugLineOe  <= next_lineOe;
      debugLineOut <= 1'b0; // open drain: only ever pulls low
    end
  end

  // ----------------------------------------------------------------
  // registers, debug mode, runtime counter, bus slave
  // ----------------------------------------------------------------
  // decode: only the low byte of haddr matters, so the map mirrors
  assign addrAcc = hsel && hready && htrans[1];
  assign rdRxd   = addrAcc && !hwrite && (haddr[7:0] == RXD_OFS);
  assign wCtrl   = wrPend && (wrAddr == CTRL_OFS);
  assign wStat   = wrPend && (wrAddr == STAT_OFS);
  assign wTxd    = wrPend && (wrAddr == TXD_OFS);

  // next-value logic for the register side
  always_comb begin
    next_ctrl = ctrl;
    if (postRst && strapLow) begin
      next_ctrl[MODE_BIT] = 1'b1;
    end
    if (wCtrl) begin
      next_ctrl = hwdata[7:0];
      if (flashReadProtect && ctrl[MODE_BIT]) begin
        next_ctrl[MODE_BIT] = 1'b1;
      end
    end
    // breakpoint wins over a clearing write in the same cycle
    if (breakpointHit && ctrl[BPEN_BIT]) begin
      next_ctrl[MODE_BIT] = 1'b1;
    end
    // link errors never touch ctrl only rstn or a CTRL_OFS write clears it
    next_txPending = (txPending && !txStart) || wTxd;
    next_txByte    = wTxd ? hwdata[7:0] : txByte;
    next_rxData    = rxDone ? rxShift : rxData;
    next_rxFull    = (rxFull && !rdRxd) || rxDone;
    next_errFlags  = (wStat ? (errFlags & ~hwdata[ST_ERR +: 3]) : errFlags)
                     | {txColl, frameErr, breakHit};
    // restart on leaving debug mode, freeze inside it, saturate
    if (ctrl[MODE_BIT] && !next_ctrl[MODE_BIT]) begin
      next_runtime = 16'h0;
    end else if (!ctrl[MODE_BIT] && runtime != RUN_MAX) begin
      next_runtime = runtime + 16'h1;
    end else begin
      next_runtime = runtime;
    end
    next_wdRefresh   = ctrl[MODE_BIT] && watchdogEnabled;
    next_sysResetReq = deepStop && !debugLineIn;
    next_wrPend      = addrAcc && hwrite;
    next_wrAddr      = addrAcc ? haddr[7:0] : wrAddr;
    // read data latched at the address phase, shown in the data phase
    next_hrdata = 32'h0;
    if (addrAcc && !hwrite) begin
      case (haddr[7:0])
        CTRL_OFS: next_hrdata = {24'h0, ctrl};
        STAT_OFS: next_hrdata = {21'h0, state, 1'b0, errFlags, rxFull, txBusy || txPending,
                                 calibrated, ctrl[MODE_BIT]};
        RXD_OFS:  next_hrdata = {24'h0, rxData};
        BAUD_OFS: next_hrdata = 32'(bitPeriod);
        RUN_OFS:  next_hrdata = {16'h0, runtime};
        default:  next_hrdata = 32'h0; // unmapped and write-only read zero
      endcase
    end
  end

  // register-side flip-flops
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl            <= CTRL_RST;
      txPending       <= 1'b0;
      txByte          <= 8'h00;
      rxData          <= 8'h00;
      rxFull          <= 1'b0;
      errFlags        <= 3'h0;
      runtime         <= 16'h0;
      wrPend          <= 1'b0;
      wrAddr          <= 8'h00;
      hrdata          <= 32'h0;
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
      cpuIdle         <= 1'b0;
      watchdogRefresh <= 1'b0;
      sysResetReq     <= 1'b0;
      postRst         <= 1'b1;
    end else begin
      ctrl            <= next_ctrl;
      txPending       <= next_txPending;
      txByte          <= next_txByte;
      rxData          <= next_rxData;
      rxFull          <= next_rxFull;
      errFlags        <= next_errFlags;
      runtime         <= next_runtime;
      wrPend          <= next_wrPend;
      wrAddr          <= next_wrAddr;
      hrdata          <= next_hrdata;
      hreadyout       <= 1'b1; // zero wait states
      hresp           <= 1'b0; // always okay
      cpuIdle         <= next_ctrl[MODE_BIT];
      watchdogRefresh <= next_wdRefresh;
      sysResetReq     <= next_sysResetReq;
      postRst         <= 1'b0;
    end
  end

  // line level seen in the last reset cycle (reset is synchronous)
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      strapLow <= ~debugLineIn;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  protect_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
    flashReadProtect && ctrl[MODE_BIT] |=> ctrl[MODE_BIT])
    else $error("protected debug mode bit was cleared");
  brk_enter_a: assert property (@(posedge core_clk) disable iff (!rstn)
    breakpointHit && ctrl[BPEN_BIT] |=> ctrl[MODE_BIT] ##1 cpuIdle)
    else $error("enabled breakpoint did not enter debug mode");
  brk_ignore_a: assert property (@(posedge core_clk) disable iff (!rstn)
    breakpointHit && !ctrl[BPEN_BIT] && !ctrl[MODE_BIT] && !wCtrl && !postRst |=> !ctrl[MODE_BIT])
    else $error("disabled breakpoint entered debug mode");
  run_count_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (!ctrl[MODE_BIT] && runtime != RUN_MAX) ##1 !ctrl[MODE_BIT] |-> runtime == $past(runtime) + 16'h1)
    else $error("runtime counter did not advance");
  run_freeze_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ctrl[MODE_BIT] ##1 ctrl[MODE_BIT] |-> $stable(runtime))
    else $error("runtime counter moved in debug mode");
  wd_refresh_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ctrl[MODE_BIT] && watchdogEnabled |=> watchdogRefresh)
    else $error("watchdog not refreshed in debug mode");
  stop_wake_a: assert property (@(posedge core_clk) disable iff (!rstn)
    deepStop && !debugLineIn |=> sysResetReq)
    else $error("low line in deep stop gave no reset request");
  err_drive_a: assert property (@(posedge core_clk) disable iff (!rstn)
    frameErr || txColl |=> state == LK_ERR ##1 debugLineOe)
    else $error("serial error did not start the answering break");
  half_duplex_a: assert property (@(posedge core_clk) disable iff (!rstn)
    state == LK_RX |-> !txBusy)
    else $error("transmitter busy while receiving");
  hold_line_a: assert property (@(posedge core_clk) disable iff (!rstn)
    state == LK_HOLD && !debugLineIn |=> state == LK_HOLD && !calibrated)
    else $error("unit left reset while line low");

endmodule

// File: tb/host_debug_model.sv
// host_debug_model: host end of the open-drain debug line
// assumes: pull-up on the line, resolved level fed back as lineLvl
`timescale 1ns/1ps
module host_debug_model #(
  parameter int BP = 8 // host clocks per bit, at most clock over 4
)(
  input  wire logic core_clk,
  input  wire logic lineLvl,
  output logic      hostOe
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] got[$]; // bytes heard from the device
  logic       listen; // off while breaks fly, they are not bytes
  initial hostOe = 1'b0;
  initial listen = 1'b0;
  // pull or release for n clocks; released means the pull-up wins
  task automatic hold(input logic pull, input int n);
    hostOe <= pull;
    repeat (n) @(posedge core_clk);
  endtask
  // one character; stopHi low makes a framing fault on purpose
  task automatic sendByte(input logic [7:0] b, input logic stopHi);
    hold(1'b1, BP);
    for (int i = 0; i < 8; i++) hold(!b[i], BP);
    hold(!stopHi, BP);
    hold(1'b0, BP / 2);
  endtask
  // receiver: mid-bit samples on falling clock, where the line is settled
  initial forever begin
    logic [7:0] b;
    @(negedge lineLvl);
    if (listen && !hostOe) begin
      repeat (BP / 2) @(negedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BP) @(negedge core_clk);
        b[i] = lineLvl;
      end
      got.push_back(b);
    end
  end
endmodule

// File: tb/one_wire_debug_port_bench.sv
// one_wire_debug_port_bench: self-checking bench of the debug port
// assumes: host model on the line, bench as the only ahb-lite master
`timescale 1ns/1ps
module one_wire_debug_port_bench import one_wire_debug_pkg::*;;
  // ----------------------------------------------------------------
  // signals and counters
  // ----------------------------------------------------------------
  logic core_clk, rstn, hsel, hwrite, hready, hreadyout, hresp, breakpointHit;
  logic flashReadProtect, watchdogEnabled, deepStop, cpuIdle, watchdogRefresh;
  logic sysResetReq, debugLineOut, debugLineOe, hostOe, lineLvl;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int n_fail, samples_checked, cycles, seed;
  assign hready = hreadyout;
  assign lineLvl = !(debugLineOe | hostOe); // open drain with pull-up
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = !core_clk;
  end
  one_wire_debug_port #(.MAX_BIT_CLKS(16)) one_wire_debug_port_i (.core_clk(core_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .debugLineIn(lineLvl),
    .debugLineOut(debugLineOut), .debugLineOe(debugLineOe), .breakpointHit(breakpointHit),
    .flashReadProtect(flashReadProtect), .watchdogEnabled(watchdogEnabled), .deepStop(deepStop),
    .cpuIdle(cpuIdle), .watchdogRefresh(watchdogRefresh), .sysResetReq(sysResetReq));
  host_debug_model #(.BP(8)) host_debug_model_i (.core_clk(core_clk), .lineLvl(lineLvl), .hostOe(hostOe));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // ready is read on the falling edge, the value the next rising edge samples
  task automatic waitRdy(output logic [31:0] r);
    logic rdy;
    do begin
      @(negedge core_clk);
      r = hrdata;
      rdy = hreadyout;
      @(posedge core_clk);
    end while (rdy !== 1'b1);
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    waitRdy(r);
    htrans <= 2'b00;
    hwdata <= d;
    waitRdy(r);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic cal;
    logic [31:0] r;
    host_debug_model_i.sendByte(8'h80, 1'b1);
    xfer(1'b0, BAUD_OFS, 32'h0, r);
    chk(r, 32'd8);
  endtask
  // after a fault: device break, hold, then uncalibrated; e picks the flag
  task automatic recover(input int e);
    logic [31:0] r;
    repeat (420) @(posedge core_clk);
    xfer(1'b0, STAT_OFS, 32'h0, r);
    chk({31'h0, r[ST_ERR+e]}, 32'h1);
    xfer(1'b0, BAUD_OFS, 32'h0, r);
    chk(r, 32'h0);
    xfer(1'b1, STAT_OFS, 32'h70, r);
    cal();
  endtask
  task automatic pulseBp;
    breakpointHit <= 1'b1;
    @(posedge core_clk);
    breakpointHit <= 1'b0;
  endtask
  // timeout well above the few thousand cycles of the sequence
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r, r2;
    logic [7:0]  b;
    {hsel, htrans, hwrite, haddr, hwdata, breakpointHit, flashReadProtect, watchdogEnabled, deepStop} = '0;
    hsize = 3'b010;
    rstn = 1'b0;
    seed = 32'hd6bb;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    xfer(1'b0, CTRL_OFS, 32'h0, r);
    chk(r, {24'h0, CTRL_RST});
    cal();
    for (int k = 0; k < 3; k++) begin
      b = 8'($random(seed)) | 8'h40; // 00h would be nine low bits, a break
      host_debug_model_i.sendByte(b, 1'b1);
      xfer(1'b0, RXD_OFS, 32'h0, r);
      chk(r, {24'h0, b});
    end
    host_debug_model_i.listen = 1'b1;
    b = 8'($random(seed));
    xfer(1'b1, TXD_OFS, {24'h0, b}, r);
    for (int k = 0; k < 300 && host_debug_model_i.got.size() == 0; k++) @(posedge core_clk);
    chk({24'h0, host_debug_model_i.got.size() ? host_debug_model_i.got.pop_front() : 8'hxx}, {24'h0, b});
    host_debug_model_i.listen = 1'b0;
    repeat (20) @(posedge core_clk);
    xfer(1'b0, RUN_OFS, 32'h0, r);
    xfer(1'b0, RUN_OFS, 32'h0, r2);
    chk({31'h0, r2 > r}, 32'h1);
    pulseBp();
    xfer(1'b0, CTRL_OFS, 32'h0, r);
    chk(r, 32'h0);
    xfer(1'b1, CTRL_OFS, 32'h20, r);
    pulseBp();
    watchdogEnabled <= 1'b1;
    xfer(1'b0, CTRL_OFS, 32'h0, r);
    chk(r, 32'ha0);
    chk({30'h0, cpuIdle, watchdogRefresh}, 32'h3);
    xfer(1'b0, RUN_OFS, 32'h0, r);
    xfer(1'b0, RUN_OFS, 32'h0, r2);
    chk(r2, r);
    flashReadProtect <= 1'b1;
    xfer(1'b1, CTRL_OFS, 32'h20, r);
    xfer(1'b0, CTRL_OFS, 32'h0, r);
    chk(r, 32'ha0);
    deepStop <= 1'b1;
    host_debug_model_i.hold(1'b1, 96);
    chk({29'h0, debugLineOut, debugLineOe, sysResetReq}, 32'h3);
    deepStop <= 1'b0;
    host_debug_model_i.hold(1'b0, 1);
    recover(0);
    xfer(1'b0, CTRL_OFS, 32'h0, r);
    chk(r, 32'ha0);
    host_debug_model_i.sendByte(8'($random(seed)) | 8'h80, 1'b0);
    recover(1);
    xfer(1'b1, TXD_OFS, 32'hff, r);
    repeat (24) @(posedge core_clk);
    host_debug_model_i.hold(1'b1, 8);
    host_debug_model_i.hold(1'b0, 1);
    recover(2);
    flashReadProtect <= 1'b0;
    xfer(1'b1, CTRL_OFS, 32'h0, r);
    xfer(1'b0, RUN_OFS, 32'h0, r);
    chk({30'h0, cpuIdle, r < 32'd64}, 32'h1);
    // mid-run reset with the line held low through its last cycle
    rstn <= 1'b0;
    host_debug_model_i.hold(1'b1, 4);
    rstn <= 1'b1;
    host_debug_model_i.hold(1'b0, 2);
    xfer(1'b0, CTRL_OFS, 32'h0, r);
    chk(r, 32'h80);
    final_report();
  end
endmodule
